// ===== logic/adcfg_fmt_decode.sv
// Serial format code decoder with fallback for unused codes
`timescale 1ns/100ps
`default_nettype none

module adcfg_fmt_decode
	import adcfg_pkg::*;
(
	// Raw field
	input wire logic [2:0] code,
	// Decoded format
	output var adcfg_fmt_t fmt
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Legal codes map straight, unused codes fall back to I2S
	always_comb begin
		unique case (code)
			3'h0: fmt = ADCFG_FMT_I2S;
			3'h1: fmt = ADCFG_FMT_LSB16;
			3'h2: fmt = ADCFG_FMT_LSB18;
			3'h3: fmt = ADCFG_FMT_LSB20;
			3'h4: fmt = ADCFG_FMT_LSB24;
			3'h5: fmt = ADCFG_FMT_MSB;
			default: fmt = ADCFG_FMT_I2S;
		endcase
	end

endmodule // adcfg_fmt_decode
`default_nettype wire

// ===== logic/adcfg_top.sv
// Audio digital I/O configuration registers and their decoded controls
`timescale 1ns/100ps
`default_nettype none
`include "adcfg_regs.svh"

// Contract
// (R01) Divider codes 01100..10001 give 24/48/96 kHz; lowest bit picks 384 fs.
// (R02) Mode field is plain binary, values 0..15 select modes 0..15.
// (R03) Output register bit 8 set mutes the digital output; clear passes audio.
// (R04) Output register bit 7 powers the digital output; resets to one.
// (R05) Registers run on their own clock, reachable while interfaces are down.
// (R06) Bits 5:4 pick output source: ADC, digital in, IEC receiver, mixer.
// (R07) Selected source without valid data is replaced by the default source.
// (R08) Output format: 000 I2S, 001..100 LSB 16/18/20/24, 101 MSB-justified.
// (R09) Output format codes 110 and 111 fall back to the default format.
// (R10) Input register bit 7 powers the digital input; resets to one.
// (R11) Input format bits 2:0 decode like output; 110/111 give default.
// (R12) Divider picks rate and 256/384 fs clock; bit clock 64 or 48 fs.
// (R13) Mode field selects how the functional blocks are interconnected.
// (R14) Reserved bits read as zero; written values there are ignored.
module adcfg_top
	import adcfg_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Register port
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [15:0] wr_data,
	output logic [15:0] rd_data,
	output logic rd_valid,
	// Source validity in the current application
	input wire logic [3:0] src_valid,
	// Decoded controls
	output var adcfg_sys_t sys_cfg,
	output var adcfg_out_t out_cfg,
	output var adcfg_in_t in_cfg
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (ADDR_W < 2 || ADDR_W > 8) begin : g_addr_check
		$error("adcfg_top: ADDR_W must be 2 to 8");
	end

	adcfg_state_t state;
	adcfg_state_t next_s;
	adcfg_fmt_t out_fmt_dec;
	adcfg_fmt_t in_fmt_dec;
	logic [7:0] addr8;
	logic hit_sys;
	logic hit_out;
	logic hit_in;
	logic sel_ok;

	// Address compare at the documented width
	assign addr8 = 8'(addr);
	assign hit_sys = (addr8 == `ADCFG_SYS_OFS);
	assign hit_out = (addr8 == `ADCFG_OUT_OFS);
	assign hit_in = (addr8 == `ADCFG_IN_OFS);

	// ----------------------------------------------------------------
	// Format decoders
	// ----------------------------------------------------------------
	adcfg_fmt_decode u_out_fmt (
		.code(next_s.regs.out_serial_format),
		.fmt(out_fmt_dec)
	);

	adcfg_fmt_decode u_in_fmt (
		.code(next_s.regs.in_serial_format),
		.fmt(in_fmt_dec)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = state;
		next_s.rd_valid = rd_en;
		// Writes land on clk_sys alone, never gated by interface power see (R05)
		if (wr_en && hit_sys) begin
			next_s.regs.crystal_rate_divider = wr_data[`ADCFG_DIV_MSB:`ADCFG_DIV_LSB];
			next_s.regs.mode = wr_data[`ADCFG_MODE_MSB:`ADCFG_MODE_LSB];
		end
		// Only named fields are stored, reserved bits dropped see (R14)
		if (wr_en && hit_out) begin
			next_s.regs.out_mute = wr_data[`ADCFG_MUTE_BIT];
			next_s.regs.out_power_on = wr_data[`ADCFG_PON_BIT];
			next_s.regs.out_source_select = wr_data[`ADCFG_SRC_MSB:`ADCFG_SRC_LSB];
			next_s.regs.out_serial_format = wr_data[`ADCFG_FMT_MSB:`ADCFG_FMT_LSB];
		end
		if (wr_en && hit_in) begin
			next_s.regs.in_power_on = wr_data[`ADCFG_PON_BIT];
			next_s.regs.in_serial_format = wr_data[`ADCFG_FMT_MSB:`ADCFG_FMT_LSB];
		end
		// Read mux, reserved and unmapped read as zero see (R14)
		next_s.rd_data = 16'h0000;
		if (rd_en && hit_sys) begin
			next_s.rd_data[`ADCFG_DIV_MSB:`ADCFG_DIV_LSB] = state.regs.crystal_rate_divider;
			next_s.rd_data[`ADCFG_MODE_MSB:`ADCFG_MODE_LSB] = state.regs.mode;
		end else if (rd_en && hit_out) begin
			next_s.rd_data[`ADCFG_MUTE_BIT] = state.regs.out_mute;
			next_s.rd_data[`ADCFG_PON_BIT] = state.regs.out_power_on;
			next_s.rd_data[`ADCFG_SRC_MSB:`ADCFG_SRC_LSB] = state.regs.out_source_select;
			next_s.rd_data[`ADCFG_FMT_MSB:`ADCFG_FMT_LSB] = state.regs.out_serial_format;
		end else if (rd_en && hit_in) begin
			next_s.rd_data[`ADCFG_PON_BIT] = state.regs.in_power_on;
			next_s.rd_data[`ADCFG_FMT_MSB:`ADCFG_FMT_LSB] = state.regs.in_serial_format;
		end else if (!rd_en) begin
			next_s.rd_data = state.rd_data;
		end
		// Rate decode of the 48 kHz family see (R01)
		next_s.sys.rate = ADCFG_RATE_NONE;
		unique case (next_s.regs.crystal_rate_divider[4:1])
			4'h6: next_s.sys.rate = ADCFG_RATE_24K;
			4'h7: next_s.sys.rate = ADCFG_RATE_48K;
			4'h8: next_s.sys.rate = ADCFG_RATE_96K;
			default: next_s.sys.rate = ADCFG_RATE_NONE;
		endcase
		next_s.sys.rate_valid = (next_s.sys.rate != ADCFG_RATE_NONE);
		// Clock multiple and bit clock ratio see (R12)
		next_s.sys.sysclk_384 = next_s.regs.crystal_rate_divider[0];
		next_s.sys.bclk_64 = !next_s.regs.crystal_rate_divider[0];
		// Application mode as plain binary and one-hot see (R02) (R13)
		next_s.sys.mode = next_s.regs.mode;
		next_s.sys.mode_onehot = 16'h0001 << next_s.regs.mode;
		// Output controls see (R03) (R04)
		next_s.dout.mute = next_s.regs.out_mute;
		next_s.dout.power_on = next_s.regs.out_power_on;
		// Source select with fallback see (R06) (R07)
		sel_ok = src_valid[next_s.regs.out_source_select];
		next_s.dout.source = sel_ok ? adcfg_src_t'(next_s.regs.out_source_select)
			: adcfg_src_t'(`ADCFG_SRC_RST);
		// Formats see (R08) (R09) (R11)
		next_s.dout.fmt = out_fmt_dec;
		next_s.din.power_on = next_s.regs.in_power_on;
		next_s.din.fmt = in_fmt_dec;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
			state.regs.crystal_rate_divider <= `ADCFG_DIV_RST;
			state.regs.mode <= `ADCFG_MODE_RST;
			state.regs.out_mute <= `ADCFG_MUTE_RST;
			state.regs.out_power_on <= `ADCFG_PON_RST; // see (R04)
			state.regs.out_source_select <= `ADCFG_SRC_RST;
			state.regs.out_serial_format <= `ADCFG_FMT_RST;
			state.regs.in_power_on <= `ADCFG_PON_RST; // see (R10)
			state.regs.in_serial_format <= `ADCFG_FMT_RST;
			state.sys.mode <= `ADCFG_MODE_RST;
			state.sys.mode_onehot <= 16'h0004;
			state.sys.bclk_64 <= `ADCFG_BCLK64_RST; // 256 fs reset divider, 64 fs bit clock see (R12)
			state.dout.power_on <= `ADCFG_PON_RST;
			state.dout.source <= ADCFG_SRC_IEC;
			state.din.power_on <= `ADCFG_PON_RST;
		end else begin
			state <= next_s;
		end
	end

	// Outputs straight from flip-flops
	assign rd_data = state.rd_data;
	assign rd_valid = state.rd_valid;
	assign sys_cfg = state.sys;
	assign out_cfg = state.dout;
	assign in_cfg = state.din;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [1:0] chk_sel;
	assign chk_sel = next_s.regs.out_source_select;

	sequence wr_out_s;
		wr_en && hit_out;
	endsequence

	sequence rd_in_s;
		rd_en && hit_in && !wr_en;
	endsequence

	mute_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wr_out_s |=> out_cfg.mute == $past(wr_data[8])) // see (R03)
		else $error("mute does not follow written bit");

	out_power_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wr_out_s ##1 rd_en && hit_out && !wr_en |=> rd_data[7] == out_cfg.power_on) // see (R04)
		else $error("output power readback mismatch");

	powered_down_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		((!out_cfg.power_on && !in_cfg.power_on) and wr_out_s) |=> out_cfg.power_on == $past(wr_data[7])) // see (R05)
		else $error("write lost while interfaces powered down");

	source_pick_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		1'b1 |=> out_cfg.source == ($past(src_valid[chk_sel]) ? adcfg_src_t'($past(chk_sel)) : ADCFG_SRC_IEC)) // see (R06) (R07)
		else $error("output source selection wrong");

	out_fmt_fallback_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_out_s and (wr_data[2:1] == 2'h3)) |=> out_cfg.fmt == ADCFG_FMT_I2S) // see (R09)
		else $error("unused output format not defaulted");

	out_fmt_decode_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_out_s and (wr_data[2:0] == 3'h4)) |=> out_cfg.fmt == ADCFG_FMT_LSB24) // see (R08)
		else $error("output format code 100 not 24 bit LSB");

	in_fmt_decode_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wr_en && hit_in |=> in_cfg.fmt == ($past(wr_data[2:1]) == 2'h3 ? ADCFG_FMT_I2S
			: adcfg_fmt_t'($past(wr_data[2:0])))) // see (R11)
		else $error("input format decode wrong");

	in_power_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wr_en && hit_in |=> in_cfg.power_on == $past(wr_data[7])) // see (R10)
		else $error("input power does not follow written bit");

	rate_decode_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		sys_cfg.rate_valid |-> sys_cfg.sysclk_384 != sys_cfg.bclk_64 &&
			(sys_cfg.rate == ADCFG_RATE_48K) == ($past(next_s.regs.crystal_rate_divider[4:1]) == 4'h7)) // see (R01) (R12)
		else $error("rate decode inconsistent");

	mode_onehot_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wr_en && hit_sys |=> sys_cfg.mode == $past(wr_data[7:4]) &&
			sys_cfg.mode_onehot == (16'h0001 << $past(wr_data[7:4]))) // see (R02)
		else $error("mode one-hot does not match mode");

	reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		rd_in_s |=> rd_valid && rd_data[15:8] == 8'h00 && rd_data[6:3] == 4'h0) // see (R14)
		else $error("reserved input bits not zero");

endmodule // adcfg_top
`default_nettype wire

// ===== shared/adcfg_pkg.sv
// Types shared by the audio digital I/O configuration slice
package adcfg_pkg;

	// Serial formats after decode
	typedef enum logic [2:0] {
		ADCFG_FMT_I2S = 3'h0,
		ADCFG_FMT_LSB16 = 3'h1,
		ADCFG_FMT_LSB18 = 3'h2,
		ADCFG_FMT_LSB20 = 3'h3,
		ADCFG_FMT_LSB24 = 3'h4,
		ADCFG_FMT_MSB = 3'h5
	} adcfg_fmt_t;

	// Digital output sources
	typedef enum logic [1:0] {
		ADCFG_SRC_ADC = 2'h0,
		ADCFG_SRC_DIGIN = 2'h1,
		ADCFG_SRC_IEC = 2'h2,
		ADCFG_SRC_MIXER = 2'h3
	} adcfg_src_t;

	// Sample rates of the 48 kHz family
	typedef enum logic [1:0] {
		ADCFG_RATE_NONE = 2'h0,
		ADCFG_RATE_24K = 2'h1,
		ADCFG_RATE_48K = 2'h2,
		ADCFG_RATE_96K = 2'h3
	} adcfg_rate_t;

	// Stored register fields
	typedef struct packed {
		logic [4:0] crystal_rate_divider;
		logic [3:0] mode;
		logic out_mute;
		logic out_power_on;
		logic [1:0] out_source_select;
		logic [2:0] out_serial_format;
		logic in_power_on;
		logic [2:0] in_serial_format;
	} adcfg_fields_t;

	// Decoded system settings
	typedef struct packed {
		adcfg_rate_t rate;
		logic rate_valid;
		logic sysclk_384;
		logic bclk_64;
		logic [3:0] mode;
		logic [15:0] mode_onehot;
	} adcfg_sys_t;

	// Decoded digital output settings
	typedef struct packed {
		logic mute;
		logic power_on;
		adcfg_src_t source;
		adcfg_fmt_t fmt;
	} adcfg_out_t;

	// Decoded digital input settings
	typedef struct packed {
		logic power_on;
		adcfg_fmt_t fmt;
	} adcfg_in_t;

	// Whole state of the slice
	typedef struct packed {
		adcfg_fields_t regs;
		adcfg_sys_t sys;
		adcfg_out_t dout;
		adcfg_in_t din;
		logic [15:0] rd_data;
		logic rd_valid;
	} adcfg_state_t;

endpackage

// ===== shared/adcfg_regs.svh
// Register offsets, field positions, reset values for the audio digital I/O configuration slice
`ifndef ADCFG_REGS_SVH
`define ADCFG_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADCFG_SYS_OFS 8'h00
`define ADCFG_OUT_OFS 8'h01
`define ADCFG_IN_OFS 8'h02

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCFG_DIV_LSB 8
`define ADCFG_DIV_MSB 12
`define ADCFG_MODE_LSB 4
`define ADCFG_MODE_MSB 7
`define ADCFG_MUTE_BIT 8
`define ADCFG_PON_BIT 7
`define ADCFG_SRC_LSB 4
`define ADCFG_SRC_MSB 5
`define ADCFG_FMT_LSB 0
`define ADCFG_FMT_MSB 2

// ----------------------------------------------------------------
// Reset values and decode limits
// ----------------------------------------------------------------
`define ADCFG_DIV_RST 5'h08
`define ADCFG_MODE_RST 4'h2
`define ADCFG_MUTE_RST 1'h0
`define ADCFG_PON_RST 1'h1
`define ADCFG_SRC_RST 2'h2
`define ADCFG_FMT_RST 3'h0
`define ADCFG_BCLK64_RST 1'h1
`define ADCFG_DIV48_LO 5'h0c
`define ADCFG_DIV48_HI 5'h11

`endif

// ===== tb/tb_adcfg_top.sv
// Self-checking bench for the audio digital I/O configuration slice
`timescale 1ns/100ps
`default_nettype none
`include "adcfg_regs.svh"

module tb_adcfg_top
	import adcfg_pkg::*;
;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wr_data = 16'h0000;
	logic [3:0] src_valid = 4'hf;
	logic [15:0] rd_data;
	logic rd_valid;
	adcfg_sys_t sys_cfg;
	adcfg_out_t out_cfg;
	adcfg_in_t in_cfg;
	int n_errors = 0;
	int samples_checked = 0;
	logic [15:0] got;

	adcfg_top #(.ADDR_W(8)) adcfg_top_inst (
		.clk_sys(clk_sys), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .src_valid(src_valid),
		.sys_cfg(sys_cfg), .out_cfg(out_cfg), .in_cfg(in_cfg)
	);

	// 125 MHz clock
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// Compare, bus and closing tasks
	// ----------------------------------------------------------------
	task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string m);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic chk_sys(input adcfg_sys_t e, input string m);
		samples_checked++;
		if (sys_cfg !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, sys_cfg, e);
		end
	endtask

	task automatic chk_out(input adcfg_out_t e, input string m);
		samples_checked++;
		if (out_cfg !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, out_cfg, e);
		end
	endtask

	task automatic chk_in(input adcfg_in_t e, input string m);
		samples_checked++;
		if (in_cfg !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, in_cfg, e);
		end
	endtask

	// One write cycle, then one idle cycle for outputs to settle
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys); #1;
		wr_en = 1'b1; addr = a; wr_data = d;
		@(posedge clk_sys); #1;
		wr_en = 1'b0;
		@(posedge clk_sys); #1;
	endtask

	// One read cycle; data and valid are taken one cycle later
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys); #1;
		rd_en = 1'b1; addr = a;
		@(posedge clk_sys); #1;
		rd_en = 1'b0;
		d = rd_data;
		chk_word({15'h0, rd_valid}, 16'h0001, "read valid");
	endtask

	task automatic do_reset();
		reset_n = 1'b0;
		repeat (10) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	task automatic complete_run();
		$display("Checks made %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Expected format after fallback of unused codes
	function automatic adcfg_fmt_t efmt(input logic [2:0] c);
		return (c > 3'h5) ? ADCFG_FMT_I2S : adcfg_fmt_t'(c);
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		do_reset();
		chk_sys('{ADCFG_RATE_NONE, 1'b0, 1'b0, 1'b1, 4'h2, 16'h0004}, "sys reset");
		chk_out('{1'b0, 1'b1, ADCFG_SRC_IEC, ADCFG_FMT_I2S}, "out reset");
		chk_in('{1'b1, ADCFG_FMT_I2S}, "in reset");
		rd(`ADCFG_SYS_OFS, got);
		chk_word(got, 16'h0820, "sys reg reset");
		rd(`ADCFG_OUT_OFS, got);
		chk_word(got, 16'h00a0, "out reg reset");
		rd(`ADCFG_IN_OFS, got);
		chk_word(got, 16'h0080, "in reg reset");
		$display("test reset done");
	endtask

	// Dividers both sides of the 48 kHz family, every mode
	task automatic test_sys();
		logic [4:0] dv;
		logic [3:0] md;
		adcfg_sys_t e;
		for (int i = 0; i < 20; i++) begin
			dv = 5'h0a + 5'(i);
			md = 4'(i);
			wr(`ADCFG_SYS_OFS, {3'h7, dv, md, 4'hf});
			e.rate_valid = (dv >= 5'h0c && dv <= 5'h11);
			e.rate = e.rate_valid ? adcfg_rate_t'(((dv - 5'h0c) >> 1) + 5'h1) : ADCFG_RATE_NONE;
			e.sysclk_384 = dv[0];
			e.bclk_64 = ~dv[0];
			e.mode = md;
			e.mode_onehot = 16'h0001 << md;
			chk_sys(e, "sys decode");
			rd(`ADCFG_SYS_OFS, got);
			chk_word(got, {3'h0, dv, md, 4'h0}, "sys readback");
		end
		$display("test sys done");
	endtask

	// Every format, source and mute combination, power tied to mute xor format bit 0, with reserved bits set
	task automatic test_out();
		logic [5:0] v;
		for (int i = 0; i < 64; i++) begin
			v = 6'(i);
			wr(`ADCFG_OUT_OFS, {7'h7f, v[5], v[5] ^ v[0], 1'b1, v[4:3], 1'b1, v[2:0]});
			chk_out('{v[5], v[5] ^ v[0], adcfg_src_t'(v[4:3]), efmt(v[2:0])}, "out decode");
			rd(`ADCFG_OUT_OFS, got);
			chk_word(got, {7'h0, v[5], v[5] ^ v[0], 1'b0, v[4:3], 1'b0, v[2:0]}, "out readback");
		end
		$display("test out done");
	endtask

	// Selected source without valid data falls back to the receiver
	task automatic test_fallback();
		for (int s = 0; s < 4; s++) begin
			if (s != 2) begin
				src_valid = ~(4'h1 << s);
				wr(`ADCFG_OUT_OFS, {10'h002, 2'(s), 4'h0});
				chk_out('{1'b0, 1'b1, ADCFG_SRC_IEC, ADCFG_FMT_I2S}, "source fallback");
				src_valid = 4'hf;
				repeat (2) @(posedge clk_sys);
				#1;
				chk_out('{1'b0, 1'b1, adcfg_src_t'(s), ADCFG_FMT_I2S}, "source restored");
			end
		end
		$display("test fallback done");
	endtask

	task automatic test_in();
		logic [3:0] v;
		for (int i = 0; i < 16; i++) begin
			v = 4'(i);
			wr(`ADCFG_IN_OFS, {8'hff, v[3], 4'hf, v[2:0]});
			chk_in('{v[3], efmt(v[2:0])}, "in decode");
			rd(`ADCFG_IN_OFS, got);
			chk_word(got, {8'h0, v[3], 4'h0, v[2:0]}, "in readback");
		end
		$display("test in done");
	endtask

	// Unmapped offsets, read pulse width, and read beside a write
	task automatic test_port();
		logic [15:0] keep;
		rd(`ADCFG_OUT_OFS, keep);
		wr(8'h03, 16'hffff);
		wr(8'hff, 16'hffff);
		rd(8'h03, got);
		chk_word(got, 16'h0000, "unmapped read");
		@(posedge clk_sys); #1;
		chk_word({15'h0, rd_valid}, 16'h0000, "valid is one pulse");
		rd(`ADCFG_OUT_OFS, got);
		chk_word(got, keep, "unmapped write ignored");
		wr(`ADCFG_IN_OFS, 16'h0081);
		@(posedge clk_sys); #1;
		wr_en = 1'b1; rd_en = 1'b1; addr = `ADCFG_IN_OFS; wr_data = 16'h0085;
		@(posedge clk_sys); #1;
		wr_en = 1'b0; rd_en = 1'b0;
		chk_word(rd_data, 16'h0081, "read beside write old");
		rd(`ADCFG_IN_OFS, got);
		chk_word(got, 16'h0085, "read after write new");
		$display("test port done");
	endtask

	// Writes with both sides powered down, then a read on the edge after a write
	task automatic test_power();
		wr(`ADCFG_IN_OFS, 16'h0000);
		wr(`ADCFG_OUT_OFS, 16'h0000);
		chk_in('{1'b0, ADCFG_FMT_I2S}, "in powered down");
		chk_out('{1'b0, 1'b0, ADCFG_SRC_ADC, ADCFG_FMT_I2S}, "out powered down");
		wr(`ADCFG_OUT_OFS, 16'h0195);
		chk_out('{1'b1, 1'b1, ADCFG_SRC_DIGIN, ADCFG_FMT_MSB}, "write while powered down");
		@(posedge clk_sys); #1;
		wr_en = 1'b1; addr = `ADCFG_OUT_OFS; wr_data = 16'h0024;
		@(posedge clk_sys); #1;
		wr_en = 1'b0; rd_en = 1'b1;
		@(posedge clk_sys); #1;
		rd_en = 1'b0;
		chk_word(rd_data, 16'h0024, "read right after write");
		chk_out('{1'b0, 1'b0, ADCFG_SRC_IEC, ADCFG_FMT_LSB24}, "out after back to back");
		$display("test power done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and run limit
	// ----------------------------------------------------------------
	initial begin
		test_reset();
		test_sys();
		test_out();
		test_fallback();
		test_in();
		test_power();
		test_port();
		test_reset();
		complete_run();
	end

	initial begin
		#200000;
		n_errors++;
		$display("CHECK FAILED at %0t: run limit reached", $time);
		complete_run();
	end

endmodule // tb_adcfg_top
`default_nettype wire
